// file: rtl/pml_regs.sv
/*
 * pml_regs.sv - indirect management register bank: auto-negotiation
 * burst timing pair, gigabit link-up time control, LED style override.
 * Assumes: one request per cycle from the management front end, never
 * read and write together; basic control register 0 value is supplied
 * on bmcr_in from the same clock domain; strap pin is asynchronous.
 */
// Contract
// - Low burst register resets to 0x4000 (8 ms); 0x1A80 means 16 ms.
// - High burst register resets to 0x0003 (8 ms); 0x0006 means 16 ms.
// - The three-bit link-up time field comes out of reset holding 100.
// - Link-up code 011 shortens link-up, safe with any partner.
// - Link-up field is reachable only while basic control is 0x2100.
// - The LED style override bit is write-only and always reads as 0.
// - An override write is copied into the status bit at position 3.
// - In both LED bits 1 is single-LED and 0 is tri-color dual-LED.
// - LED status takes the strap at reset, then moves only on override.
`timescale 1ns/100ps
`include "pml_cfg.svh"
module pml_regs (
	input  wire logic         ref_clk_in,
	input  wire logic         srst_in,
	input  pml_pkg::pml_req_t req_in,
	output pml_pkg::pml_rsp_t rsp_out,
	input  wire logic [15:0]  bmcr_in,
	input  wire logic         led_strap_in,
	output logic              led_single_out,
	output logic              flp_16ms_out,
	output logic              flp_code_ok_out,
	output logic [2:0]        linkup_code_out
);
	import pml_pkg::*;

	logic [15:0] flp_lo_r;
	logic [15:0] flp_hi_r;
	logic [2:0]  linkup_r;
	logic        led_stat_r;
	logic        strap_lvl;
	pml_rsp_t    rsp_r;
	pml_rsp_t    rsp_nxt;
	logic        forced;
	logic        hit_lo;
	logic        hit_hi;
	logic        hit_link;
	logic        hit_com;

	// ****************************************************************
	// decode
	// ****************************************************************
	assign forced   = (bmcr_in == `PML_BMCR_FORCED);
	assign hit_lo   = (req_in.dev == `PML_DEV_ANEG) &&
	                  (req_in.addr == `PML_REG_FLP_LO);
	assign hit_hi   = (req_in.dev == `PML_DEV_ANEG) &&
	                  (req_in.addr == `PML_REG_FLP_HI);
	assign hit_link = (req_in.dev == `PML_DEV_LINK) &&
	                  (req_in.addr == `PML_REG_LINKUP);
	assign hit_com  = (req_in.dev == `PML_DEV_COMMON) &&
	                  (req_in.addr == `PML_REG_COMMON);

	pml_sync3 u_strap (
		.ref_clk_in (ref_clk_in),
		.pin_in     (led_strap_in),
		.level_out  (strap_lvl)
	);

	// ****************************************************************
	// burst timing pair
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			flp_lo_r <= `PML_FLP_LO_8MS;
		end else if (req_in.wr && hit_lo) begin
			flp_lo_r <= req_in.wdata;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			flp_hi_r <= `PML_FLP_HI_8MS;
		end else if (req_in.wr && hit_hi) begin
			flp_hi_r <= req_in.wdata;
		end
	end

	// 16 ms only when both halves agree; only the 8 ms reset pair also keeps flp_code_ok_out high
	assign flp_16ms_out = (flp_lo_r == `PML_FLP_LO_16MS) &&
	                      (flp_hi_r == `PML_FLP_HI_16MS);
	assign flp_code_ok_out = flp_16ms_out ||
	                         ((flp_lo_r == `PML_FLP_LO_8MS) &&
	                          (flp_hi_r == `PML_FLP_HI_8MS));

	// ****************************************************************
	// gigabit link-up time control
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			linkup_r <= `PML_LINKUP_RST;
		end else if (req_in.wr && hit_link && forced) begin
			linkup_r <= req_in.wdata[`PML_LINKUP_MSB:`PML_LINKUP_LSB];
		end
	end
	assign linkup_code_out = linkup_r;

	// ****************************************************************
	// LED style status
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			led_stat_r <= strap_lvl;
		end else if (req_in.wr && hit_com) begin
			led_stat_r <= req_in.wdata[`PML_LED_OVR_BIT];
		end
	end
	assign led_single_out = led_stat_r;

	// ****************************************************************
	// read answer, one cycle after the request
	// ****************************************************************
	always_comb begin
		rsp_nxt.valid = req_in.rd;
		rsp_nxt.data  = 16'h0000;
		if (req_in.rd) begin
			if (hit_lo) begin
				rsp_nxt.data = flp_lo_r;
			end else if (hit_hi) begin
				rsp_nxt.data = flp_hi_r;
			end else if (hit_link && forced) begin
				rsp_nxt.data[`PML_LINKUP_MSB:`PML_LINKUP_LSB] = linkup_r;
			end else if (hit_com) begin
				// override bit stays 0 on read
				rsp_nxt.data[`PML_LED_STAT_BIT] = led_stat_r;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end
	assign rsp_out = rsp_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	sequence s_wr_link_forced;
		req_in.wr && hit_link && forced;
	endsequence
	sequence s_rd_com;
		req_in.rd && hit_com;
	endsequence
	sequence s_wr_com;
		req_in.wr && hit_com;
	endsequence

	a_flp_lo_reset: assert property (
		$fell(srst_in) |-> flp_lo_r == 16'h4000)
		else $error("low burst register not at 8 ms after reset");
	a_flp_hi_reset: assert property (
		$fell(srst_in) |-> flp_hi_r == 16'h0003)
		else $error("high burst register not at 8 ms after reset");
	a_flp_pair: assert property (
		(req_in.wr && hit_lo && req_in.wdata == 16'h1A80 &&
		 flp_hi_r == 16'h0006) |=> flp_16ms_out)
		else $error("16 ms pair not selected");
	a_flp_pair_hi: assert property (
		(req_in.wr && hit_hi && req_in.wdata == 16'h0006 &&
		 flp_lo_r == 16'h1A80) |=> flp_16ms_out)
		else $error("16 ms pair not selected after high write");
	a_linkup_reset: assert property (
		$fell(srst_in) |-> linkup_r == 3'h4)
		else $error("link-up field not 100 after reset");
	a_linkup_write: assert property (
		s_wr_link_forced |=> linkup_code_out == $past(req_in.wdata[2:0]))
		else $error("link-up write not taken in forced mode");
	a_linkup_gate: assert property (
		(req_in.wr && hit_link && !forced) |=> $stable(linkup_r))
		else $error("link-up written outside forced mode");
	a_linkup_rdgate: assert property (
		(req_in.rd && hit_link && !forced) |=> rsp_out.data == 16'h0000)
		else $error("link-up readable outside forced mode");
	a_led_wo_read: assert property (
		s_rd_com |=> rsp_out.valid && !rsp_out.data[4] &&
		rsp_out.data[3] == led_single_out)
		else $error("override bit read back nonzero");
	a_led_copy: assert property (
		s_wr_com ##1 (!req_in.wr [*2]) |-> led_single_out ==
		$past(req_in.wdata[4], 2))
		else $error("override not copied to status");
	a_led_hold: assert property (
		!(req_in.wr && hit_com) |=> $stable(led_stat_r))
		else $error("LED status changed without override write");
	a_led_out: assert property (
		s_wr_com |=> led_single_out == $past(req_in.wdata[4]))
		else $error("LED style output does not follow override");
endmodule

// file: shared/pml_cfg.svh
/*
 * pml_cfg.svh - offsets, field positions, reset values and codes of the
 * management register bank.
 * Assumes: included by bare name after the package; definitions only.
 */
`ifndef PML_CFG_SVH
`define PML_CFG_SVH

// ****************************************************************
// device and register addresses
// ****************************************************************
`define PML_DEV_ANEG      5'h00
`define PML_DEV_LINK      5'h01
`define PML_DEV_COMMON    5'h02
`define PML_REG_FLP_LO    16'h0003
`define PML_REG_FLP_HI    16'h0004
`define PML_REG_LINKUP    16'h0010
`define PML_REG_COMMON    16'h0000

// ****************************************************************
// reset values and codes
// ****************************************************************
`define PML_FLP_LO_8MS    16'h4000
`define PML_FLP_LO_16MS   16'h1A80
`define PML_FLP_HI_8MS    16'h0003
`define PML_FLP_HI_16MS   16'h0006
`define PML_LINKUP_RST    3'h4
`define PML_LINKUP_FAST   3'h3
`define PML_BMCR_FORCED   16'h2100

// ****************************************************************
// field positions
// ****************************************************************
`define PML_LINKUP_LSB    0
`define PML_LINKUP_MSB    2
`define PML_LED_OVR_BIT   4
`define PML_LED_STAT_BIT  3

`endif

// file: shared/pml_pkg.sv
/*
 * pml_pkg.sv - types carried between the register bank and its user.
 * Assumes: nothing beyond a SystemVerilog compiler.
 */
package pml_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  dev;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pml_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} pml_rsp_t;

endpackage

// file: rtl/pml_sync3.sv
/*
 * pml_sync3.sv - three-stage synchroniser for a slow pin level.
 * Assumes: the pin changes rarely; output follows once stages two and
 * three agree. No reset: the chain settles within four clock edges.
 */
`timescale 1ns/100ps
module pml_sync3 (
	input  wire logic ref_clk_in,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// ****************************************************************
	// capture chain
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	always_ff @(posedge ref_clk_in) begin
		if (s2_r == s3_r) begin
			level_out <= s3_r;
		end
	end
endmodule

// file: bench/pml_mgmt_model.sv
/*
 * pml_mgmt_model.sv - station management controller issuing register
 * requests and holding the basic control register 0 value.
 * Assumes: drives at the falling edge, the bank samples at the rising.
 */
`timescale 1ns/100ps
module pml_mgmt_model (
	input  wire logic         ref_clk_in,
	input  pml_pkg::pml_rsp_t rsp_in,
	output pml_pkg::pml_req_t req_out,
	output logic [15:0]       bmcr_out
);
	import pml_pkg::*;
	initial begin
		req_out = '0;
		bmcr_out = 16'h0000;
	end
	// released lines show the inverse of the last request
	task automatic wr(input logic [4:0] dev, input logic [15:0] addr, d);
		@(negedge ref_clk_in);
		req_out = '{1'b1, 1'b0, dev, addr, d};
		@(negedge ref_clk_in);
		req_out = '{1'b0, 1'b0, ~dev, ~addr, ~d};
	endtask
	task automatic rd(input logic [4:0] dev, input logic [15:0] addr,
		output logic [15:0] d, output logic v);
		@(negedge ref_clk_in);
		req_out = '{1'b0, 1'b1, dev, addr, req_out.wdata};
		@(negedge ref_clk_in);
		v = rsp_in.valid;
		d = rsp_in.data;
		req_out = '{1'b0, 1'b0, ~dev, ~addr, ~req_out.wdata};
	endtask
	task automatic set_bmcr(input logic [15:0] v);
		@(negedge ref_clk_in);
		bmcr_out = v;
	endtask
endmodule

// file: bench/tb_top.sv
/*
 * tb_top.sv - self-checking bench for the management register bank.
 * Assumes: pml_pkg compiled first; 250 MHz clock, inputs at falling edge.
 */
`timescale 1ns/100ps
module tb_top;
	import pml_pkg::*;
	typedef struct packed {
		logic w; logic [4:0] dev; logic [15:0] addr, data;
		logic f16, ok, led; logic [2:0] lu;
	} pml_row_t;
	logic        ref_clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        led_strap_in = 1'b0;
	pml_req_t    req;
	pml_rsp_t    rsp;
	logic [15:0] bmcr, rdata;
	logic        led, f16, ok, rvalid;
	logic [2:0]  lu;
	int          miscompares = 0;
	int          checks_done = 0;
	// write, dev, addr, data or expected read, then expected outputs
	pml_row_t rows [15] = '{
		'{1'h0, 5'h00, 16'h0003, 16'h4000, 1'h0, 1'h1, 1'h0, 3'h4},
		'{1'h0, 5'h00, 16'h0004, 16'h0003, 1'h0, 1'h1, 1'h0, 3'h4},
		'{1'h0, 5'h01, 16'h0010, 16'h0004, 1'h0, 1'h1, 1'h0, 3'h4},
		'{1'h1, 5'h00, 16'h0003, 16'h1A80, 1'h0, 1'h0, 1'h0, 3'h4},
		'{1'h1, 5'h00, 16'h0004, 16'h0006, 1'h1, 1'h1, 1'h0, 3'h4},
		'{1'h0, 5'h00, 16'h0003, 16'h1A80, 1'h1, 1'h1, 1'h0, 3'h4},
		'{1'h1, 5'h01, 16'h0010, 16'h0003, 1'h1, 1'h1, 1'h0, 3'h3},
		'{1'h0, 5'h01, 16'h0010, 16'h0003, 1'h1, 1'h1, 1'h0, 3'h3},
		'{1'h1, 5'h02, 16'h0000, 16'h0010, 1'h1, 1'h1, 1'h1, 3'h3},
		'{1'h0, 5'h02, 16'h0000, 16'h0008, 1'h1, 1'h1, 1'h1, 3'h3},
		'{1'h1, 5'h02, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0, 3'h3},
		'{1'h0, 5'h02, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0, 3'h3},
		'{1'h1, 5'h00, 16'h0003, 16'h4000, 1'h0, 1'h0, 1'h0, 3'h3},
		'{1'h1, 5'h00, 16'h0004, 16'h0003, 1'h0, 1'h1, 1'h0, 3'h3},
		'{1'h0, 5'h00, 16'h0005, 16'h0000, 1'h0, 1'h1, 1'h0, 3'h3}};

	always #2 ref_clk_in = ~ref_clk_in;

	pml_regs dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.req_in(req), .rsp_out(rsp), .bmcr_in(bmcr),
		.led_strap_in(led_strap_in), .led_single_out(led),
		.flp_16ms_out(f16), .flp_code_ok_out(ok), .linkup_code_out(lu));
	pml_mgmt_model mgmt_u (.ref_clk_in(ref_clk_in), .rsp_in(rsp),
		.req_out(req), .bmcr_out(bmcr));

	// ****************************************************************
	// checking tasks
	// ****************************************************************
	task automatic chk(input logic [15:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic outs(input logic f, o, l, input logic [2:0] c);
		chk({10'h0, f16, ok, led, lu}, {10'h0, f, o, l, c}, "outputs");
	endtask
	task automatic rdchk(input logic [4:0] d, input logic [15:0] a, e);
		mgmt_u.rd(d, a, rdata, rvalid);
		chk({15'h0, rvalid}, 16'h0001, "valid");
		chk(rdata, e, "rdata");
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		#100000;
		miscompares++;
		results();
	end
	initial begin
		repeat (10) @(negedge ref_clk_in);
		srst_in = 1'b0;
		mgmt_u.set_bmcr(16'h2100);
		foreach (rows[i]) begin
			if (rows[i].w)
				mgmt_u.wr(rows[i].dev, rows[i].addr,
					rows[i].data);
			else
				rdchk(rows[i].dev, rows[i].addr,
					rows[i].data);
			outs(rows[i].f16, rows[i].ok, rows[i].led,
				rows[i].lu);
		end
		$display("test rows done");
		mgmt_u.set_bmcr(16'h1140);
		mgmt_u.wr(5'h1, 16'h0010, 16'h0004);
		rdchk(5'h1, 16'h0010, 16'h0000);
		outs(1'h0, 1'h1, 1'h0, 3'h3);
		$display("test forced mode gate done");
		led_strap_in = 1'b1;
		srst_in = 1'b1;
		repeat (10) @(negedge ref_clk_in);
		srst_in = 1'b0;
		outs(1'h0, 1'h1, 1'h1, 3'h4);
		led_strap_in = 1'b0;
		repeat (8) @(negedge ref_clk_in);
		outs(1'h0, 1'h1, 1'h1, 3'h4);
		mgmt_u.wr(5'h2, 16'h0000, 16'h0000);
		outs(1'h0, 1'h1, 1'h0, 3'h4);
		led_strap_in = 1'b1;
		repeat (8) @(negedge ref_clk_in);
		outs(1'h0, 1'h1, 1'h0, 3'h4);
		$display("test strap reload done");
		results();
	end
endmodule
